/* File: core/mmd_pkg.sv */
// Package: constants and carrier types for the memory map decoder
`default_nettype none
package mmd_pkg;
  // Map geometry
  localparam int PAGE_BITS      = 8;
  localparam int OFFS_BITS      = 16;
  localparam int ADDR_BITS      = 24;
  localparam int IO_ADDR_BITS   = 18;
  localparam int IO_IMM_BITS    = 10;
  localparam int SRAM_BLK_BITS  = 14;
  localparam int ROM_BITS       = 10;
  localparam logic [7:0] PAGE_SRAM = 8'h00;
  localparam logic [7:0] PAGE_ROM  = 8'hFF;
  localparam logic [15:0] ROM_BASE_OFFS = 16'hFC00;
  localparam logic [7:0] IO_INT_PAGE_MAX = 8'h07;
  localparam logic [7:0] BOOT_PAGE_MAX   = 8'h3F;
  // Reset bank boundaries: first page of banks 1..3
  localparam logic [7:0] BANK1_FIRST_RST = 8'h40;
  localparam logic [7:0] BANK2_FIRST_RST = 8'h80;
  localparam logic [7:0] BANK3_FIRST_RST = 8'hC0;
  // Reset fetch address: base of boot ROM
  localparam logic [23:0] RESET_PC = 24'hFF_FC00;
  // Space control register field positions
  localparam int SC_RWAIT_LSB = 0;
  localparam int SC_WWAIT_LSB = 3;
  localparam int SC_WMODE_LSB = 6;
  localparam int SC_CDIV_LSB  = 8;
  localparam int SC_WHOLD_BIT = 11;
  localparam int SC_POL_BIT   = 12;
  localparam int SC_W8_BIT    = 13;
  localparam logic [15:0] SC_RESET = 16'h003F;

  // Per-space access parameters
  typedef struct packed {
    logic       bus8;
    logic       pol_hi;
    logic       whold;
    logic [2:0] clkdiv;
    logic [1:0] wmode;
    logic [2:0] wwait;
    logic [2:0] rwait;
  } mmd_spcfg_t;

  // Fetch address source
  typedef enum logic [1:0] {
    MMD_PC_LINEAR = 2'h0,
    MMD_PC_REL    = 2'h1,
    MMD_PC_DIRECT = 2'h2,
    MMD_PC_IND    = 2'h3
  } mmd_pcsel_t;

  // Off-chip target
  typedef enum logic [2:0] {
    MMD_T_NONE = 3'h0,
    MMD_T_BANK = 3'h1,
    MMD_T_IO   = 3'h2,
    MMD_T_BOOT = 3'h3
  } mmd_tgt_t;

  // Port state machine, one-hot
  typedef enum logic [2:0] {
    MMD_S_IDLE = 3'b001,
    MMD_S_WAIT = 3'b010,
    MMD_S_DONE = 3'b100
  } mmd_st_t;

  // A master request
  typedef struct packed {
    logic        req;
    logic        write;
    logic        io;
    logic        boot;
    logic [23:0] addr;
  } mmd_req_t;

  // Internal select outputs
  typedef struct packed {
    logic        sram;
    logic [1:0]  sram_blk;
    logic        rom;
    logic        io_int;
  } mmd_intsel_t;
endpackage : mmd_pkg
`default_nettype wire

/* File: core/mmd_decode.sv */
// Address generation, map decode and external port sequencing
`default_nettype none
module mmd_decode #(
  parameter int WAIT_BITS = 3
) (
  // Clock, reset, enable
  input  wire logic                 mclk_in,
  input  wire logic                 rst_in,
  input  wire logic                 ce_in,
  // Address generator inputs
  input  wire logic [1:0]           ag_sel_in,
  input  wire logic [15:0]          ag_ptr_in,
  input  wire logic                 data_page_we_in,
  input  wire logic [7:0]           data_page_in,
  // Sequencer inputs
  input  wire mmd_pkg::mmd_pcsel_t  pc_sel_in,
  input  wire logic                 pc_step_in,
  input  wire logic [15:0]          pc_rel_in,
  input  wire logic [23:0]          pc_direct_in,
  input  wire logic                 jump_page_we_in,
  input  wire logic [7:0]           jump_page_in,
  // I/O instruction inputs
  input  wire logic                 io_page_we_in,
  input  wire logic [7:0]           io_page_in,
  input  wire logic [9:0]           io_imm_in,
  // Space configuration
  input  wire logic [2:0]           spcfg_we_in,
  input  wire logic [15:0]          spcfg_in,
  input  wire logic [2:0]           bank_first_we_in,
  input  wire logic [7:0]           bank_first_in,
  // Masters
  input  wire mmd_pkg::mmd_req_t    core_req_in,
  input  wire mmd_pkg::mmd_req_t    dma_req_in,
  input  wire logic                 host_io_in,
  // Addresses out
  output logic [23:0]               program_addr_bus_out,
  output logic [23:0]               data_addr_out,
  output logic [17:0]               io_addr_out,
  // Internal selects
  output mmd_pkg::mmd_intsel_t      int_sel_out,
  // External port
  output logic [3:0]                bank_select_n_out,
  output logic                      io_space_select_n_out,
  output logic                      boot_space_select_n_out,
  output logic [23:0]               ext_addr_out,
  output logic                      ext_we_out,
  output logic                      ext_bus8_out,
  output logic                      ext_whold_out,
  output logic [2:0]                ext_clkdiv_out,
  // Handshake
  output logic                      core_stall_out,
  output logic                      dma_stall_out,
  output logic                      core_done_out,
  output logic                      dma_done_out
);

  // Elaboration check of the wait counter width
  if (WAIT_BITS < 3 || WAIT_BITS > 8) begin : g_bad_wait
    $error("mmd_decode: WAIT_BITS out of range");
  end

  // Whole module state
  typedef struct packed {
    logic [7:0]              data_page_reg0;
    logic [7:0]              data_page_reg1;
    logic [7:0]              jump_page_reg;
    logic [7:0]              io_page_reg;
    logic [23:0]             pc;
    logic [2:0][7:0]         bank_first;
    logic [2:0][15:0]        spcfg;
    mmd_pkg::mmd_st_t        st;
    logic                    owner_dma;
    mmd_pkg::mmd_tgt_t       tgt;
    logic [1:0]              bank;
    logic [23:0]             eaddr;
    logic                    ewe;
    logic [WAIT_BITS-1:0]    wcnt;
  } mmd_state_t;

  mmd_state_t r;
  mmd_state_t next_r;

  mmd_pkg::mmd_req_t   grant;
  logic                pick_dma;
  logic [1:0]          g_bank;
  mmd_pkg::mmd_tgt_t   g_tgt;
  mmd_pkg::mmd_spcfg_t g_cfg;
  mmd_pkg::mmd_spcfg_t a_cfg;
  logic [7:0]          g_page;
  logic [7:0]          dpage;
  logic [1:0]          e_bank;

  // Bank lookup from a page number
  function automatic logic [1:0] bank_of(input logic [7:0] pg,
                                         input logic [2:0][7:0] bf);
    logic [1:0] b;
    b = 2'h0;
    if (pg >= bf[2]) begin
      b = 2'h3;
    end else if (pg >= bf[1]) begin
      b = 2'h2;
    end else if (pg >= bf[0]) begin
      b = 2'h1;
    end
    return b;
  endfunction : bank_of

  // Data and I/O address formation
  always_comb begin
    dpage = ag_sel_in[0] ? r.data_page_reg1 : r.data_page_reg0;
    data_addr_out = {dpage, ag_ptr_in};
    io_addr_out = {r.io_page_reg, io_imm_in};
    program_addr_bus_out = r.pc;
  end

  // Internal decode of the data address and the I/O page
  always_comb begin
    int_sel_out.sram = (dpage == mmd_pkg::PAGE_SRAM);
    int_sel_out.sram_blk = ag_ptr_in[15:14];
    int_sel_out.rom = (dpage == mmd_pkg::PAGE_ROM)
                      && (ag_ptr_in >= mmd_pkg::ROM_BASE_OFFS);
    int_sel_out.io_int = (r.io_page_reg <= mmd_pkg::IO_INT_PAGE_MAX)
                         && (core_req_in.io || host_io_in);
  end

  // Fixed-priority pick; core first, dma waits
  always_comb begin
    pick_dma = !core_req_in.req && dma_req_in.req;
    grant = pick_dma ? dma_req_in : core_req_in;
    g_page = grant.addr[23:16];
    g_bank = bank_of(g_page, r.bank_first);
    g_tgt = mmd_pkg::MMD_T_NONE;
    if (grant.io) begin
      if (grant.addr[17:10] > mmd_pkg::IO_INT_PAGE_MAX) begin
        g_tgt = mmd_pkg::MMD_T_IO;
      end
    end else if (grant.boot) begin
      if (g_page <= mmd_pkg::BOOT_PAGE_MAX) begin
        g_tgt = mmd_pkg::MMD_T_BOOT;
      end
    end else if (g_page != mmd_pkg::PAGE_SRAM
                 && !(g_page == mmd_pkg::PAGE_ROM
                      && grant.addr[15:0] >= mmd_pkg::ROM_BASE_OFFS)) begin
      g_tgt = mmd_pkg::MMD_T_BANK;
    end
    case (g_tgt)
      mmd_pkg::MMD_T_IO:   g_cfg = mmd_pkg::mmd_spcfg_t'(r.spcfg[1]);
      mmd_pkg::MMD_T_BOOT: g_cfg = mmd_pkg::mmd_spcfg_t'(r.spcfg[2]);
      default:             g_cfg = mmd_pkg::mmd_spcfg_t'(r.spcfg[0]);
    endcase
  end

  // Next-state logic
  always_comb begin
    next_r = r;
    // Page registers
    if (data_page_we_in) begin
      if (ag_sel_in[0]) begin
        next_r.data_page_reg1 = data_page_in;
      end else begin
        next_r.data_page_reg0 = data_page_in;
      end
    end
    if (jump_page_we_in) begin
      next_r.jump_page_reg = jump_page_in;
    end
    if (io_page_we_in) begin
      next_r.io_page_reg = io_page_in;
    end
    for (int i = 0; i < 3; i++) begin
      if (bank_first_we_in[i]) begin
        next_r.bank_first[i] = bank_first_in;
      end
      if (spcfg_we_in[i]) begin
        next_r.spcfg[i] = spcfg_in;
      end
    end
    // Program counter
    if (pc_step_in) begin
      case (pc_sel_in)
        mmd_pkg::MMD_PC_LINEAR:
          next_r.pc = r.pc + 24'h00_0001;
        mmd_pkg::MMD_PC_REL:
          next_r.pc = r.pc + {{8{pc_rel_in[15]}}, pc_rel_in};
        mmd_pkg::MMD_PC_DIRECT:
          next_r.pc = pc_direct_in;
        default:
          next_r.pc = {r.jump_page_reg, ag_ptr_in};
      endcase
    end
    // External port sequencer
    case (r.st)
      mmd_pkg::MMD_S_IDLE: begin
        if (grant.req && g_tgt != mmd_pkg::MMD_T_NONE) begin
          next_r.st = mmd_pkg::MMD_S_WAIT;
          next_r.owner_dma = pick_dma;
          next_r.tgt = g_tgt;
          next_r.bank = g_bank;
          next_r.eaddr = grant.addr;
          next_r.ewe = grant.write;
          next_r.wcnt = WAIT_BITS'(grant.write ? g_cfg.wwait : g_cfg.rwait);
        end
      end
      mmd_pkg::MMD_S_WAIT: begin
        if (r.wcnt == '0) begin
          next_r.st = mmd_pkg::MMD_S_DONE;
        end else begin
          next_r.wcnt = r.wcnt - WAIT_BITS'(1);
        end
      end
      mmd_pkg::MMD_S_DONE: begin
        next_r.st = mmd_pkg::MMD_S_IDLE;
        next_r.tgt = mmd_pkg::MMD_T_NONE;
      end
      default: next_r.st = mmd_pkg::MMD_S_IDLE;
    endcase
  end

  // State register
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      r.data_page_reg0 <= 8'h00;
      r.data_page_reg1 <= 8'h00;
      r.jump_page_reg  <= 8'h00;
      r.io_page_reg    <= 8'h00;
      r.pc             <= mmd_pkg::RESET_PC;
      r.bank_first     <= {mmd_pkg::BANK3_FIRST_RST,
                           mmd_pkg::BANK2_FIRST_RST,
                           mmd_pkg::BANK1_FIRST_RST};
      r.spcfg          <= {3{mmd_pkg::SC_RESET}};
      r.st             <= mmd_pkg::MMD_S_IDLE;
      r.owner_dma      <= 1'b0;
      r.tgt            <= mmd_pkg::MMD_T_NONE;
      r.bank           <= 2'h0;
      r.eaddr          <= 24'h00_0000;
      r.ewe            <= 1'b0;
      r.wcnt           <= '0;
    end else if (ce_in) begin
      r <= next_r;
    end
  end

  // External strobes and stalls
  always_comb begin
    a_cfg = mmd_pkg::mmd_spcfg_t'(r.tgt == mmd_pkg::MMD_T_IO ? r.spcfg[1]
           : r.tgt == mmd_pkg::MMD_T_BOOT ? r.spcfg[2] : r.spcfg[0]);
    e_bank = r.bank;
    bank_select_n_out = 4'hF;
    if (r.tgt == mmd_pkg::MMD_T_BANK) begin
      bank_select_n_out[e_bank] = 1'b0;
    end
    io_space_select_n_out = !(r.tgt == mmd_pkg::MMD_T_IO);
    boot_space_select_n_out = !(r.tgt == mmd_pkg::MMD_T_BOOT);
    if (a_cfg.pol_hi) begin
      bank_select_n_out = ~bank_select_n_out;
      io_space_select_n_out = ~io_space_select_n_out;
      boot_space_select_n_out = ~boot_space_select_n_out;
    end
    ext_addr_out = r.eaddr;
    ext_we_out = r.ewe && (r.st != mmd_pkg::MMD_S_IDLE);
    ext_bus8_out = a_cfg.bus8;
    ext_whold_out = a_cfg.whold;
    ext_clkdiv_out = a_cfg.clkdiv;
    core_done_out = (r.st == mmd_pkg::MMD_S_DONE) && !r.owner_dma;
    dma_done_out = (r.st == mmd_pkg::MMD_S_DONE) && r.owner_dma;
    core_stall_out = core_req_in.req && !core_done_out
                     && (r.st != mmd_pkg::MMD_S_IDLE
                         || g_tgt != mmd_pkg::MMD_T_NONE);
    dma_stall_out = dma_req_in.req && !dma_done_out
                    && (r.st != mmd_pkg::MMD_S_IDLE || core_req_in.req
                        || g_tgt != mmd_pkg::MMD_T_NONE);
  end

  // Checks
  a_reset_fetch_rom: assert property (@(posedge mclk_in)
    $fell(rst_in) |-> program_addr_bus_out == mmd_pkg::RESET_PC)
    else $error("fetch not at boot ROM after reset");
  a_one_bank_low: assert property (@(posedge mclk_in)
    disable iff (rst_in)
    (r.tgt == mmd_pkg::MMD_T_BANK && !a_cfg.pol_hi)
      |-> $countones(~bank_select_n_out) == 1)
    else $error("bank select not one-hot");
  a_io_int_quiet: assert property (@(posedge mclk_in)
    disable iff (rst_in)
    (r.tgt == mmd_pkg::MMD_T_IO)
      |-> r.eaddr[17:10] > mmd_pkg::IO_INT_PAGE_MAX)
    else $error("internal I/O page driven off-chip");
  a_data_addr_form: assert property (@(posedge mclk_in)
    disable iff (rst_in)
    data_addr_out[15:0] == ag_ptr_in)
    else $error("data address low half wrong");
  a_boot_pages: assert property (@(posedge mclk_in)
    disable iff (rst_in)
    (r.tgt == mmd_pkg::MMD_T_BOOT)
      |-> r.eaddr[23:16] <= mmd_pkg::BOOT_PAGE_MAX)
    else $error("boot select beyond 63 pages");
  a_single_owner: assert property (@(posedge mclk_in)
    disable iff (rst_in)
    !(core_done_out && dma_done_out))
    else $error("two masters served at once");
  a_access_ends: assert property (@(posedge mclk_in)
    disable iff (rst_in)
    (ce_in && r.st == mmd_pkg::MMD_S_WAIT && r.wcnt == '0)
      |=> r.st == mmd_pkg::MMD_S_DONE)
    else $error("wait count not honoured");
  a_pc_linear: assert property (@(posedge mclk_in)
    disable iff (rst_in)
    (ce_in && pc_step_in && pc_sel_in == mmd_pkg::MMD_PC_LINEAR)
      |=> program_addr_bus_out == $past(program_addr_bus_out) + 24'h00_0001)
    else $error("linear fetch did not step");
  a_jump_page: assert property (@(posedge mclk_in)
    disable iff (rst_in)
    (ce_in && pc_step_in && pc_sel_in == mmd_pkg::MMD_PC_IND)
      |=> program_addr_bus_out[23:16] == $past(r.jump_page_reg))
    else $error("indirect jump page wrong");
  a_pc_direct: assert property (@(posedge mclk_in)
    disable iff (rst_in)
    (ce_in && pc_step_in && pc_sel_in == mmd_pkg::MMD_PC_DIRECT)
      |=> program_addr_bus_out == $past(pc_direct_in))
    else $error("direct target not loaded");
  a_io_strobe: assert property (@(posedge mclk_in)
    disable iff (rst_in)
    (r.tgt == mmd_pkg::MMD_T_IO && !a_cfg.pol_hi)
      |-> !io_space_select_n_out && bank_select_n_out == 4'hF)
    else $error("I/O select strobe wrong");
  a_boot_strobe: assert property (@(posedge mclk_in)
    disable iff (rst_in)
    (r.tgt == mmd_pkg::MMD_T_BOOT && !a_cfg.pol_hi)
      |-> !boot_space_select_n_out && io_space_select_n_out)
    else $error("boot select strobe wrong");
  a_rom_decode: assert property (@(posedge mclk_in)
    disable iff (rst_in)
    int_sel_out.rom |-> data_addr_out[23:10] == 14'h3FFF)
    else $error("boot ROM select outside its page");
  a_loser_stall: assert property (@(posedge mclk_in)
    disable iff (rst_in)
    (core_req_in.req && dma_req_in.req && r.st == mmd_pkg::MMD_S_WAIT
     && !r.owner_dma) |-> dma_stall_out)
    else $error("losing master not stalled");

endmodule : mmd_decode
`default_nettype wire

/* File: verification/mmd_ext_mem_model.sv */
// Model of the off-chip banks, I/O devices and boot memory
`default_nettype none
module mmd_ext_mem_model (
  // Clock
  input  wire logic        mclk_in,
  // Strobes from the external port
  input  wire logic [3:0]  bank_select_n_in,
  input  wire logic        io_space_select_n_in,
  input  wire logic        boot_space_select_n_in,
  input  wire logic [23:0] ext_addr_in,
  // What the memories saw
  output logic [2:0]       space_out,
  output logic [23:0]      addr_out,
  output logic             overlap_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [5:0] sel;

  // Space codes: 0..3 banks, 4 I/O, 5 boot
  assign sel = ~{boot_space_select_n_in, io_space_select_n_in,
                 bank_select_n_in};

  // Latch the selected device; two devices at once is a bus fight
  initial overlap_out = 1'b0;
  always @(posedge mclk_in) begin
    if ($countones(sel) > 1) begin
      overlap_out <= 1'b1;
    end
    for (int i = 0; i < 6; i++) begin
      if (sel[i] === 1'b1) begin
        space_out <= 3'(i);
        addr_out  <= ext_addr_in;
      end
    end
  end
endmodule : mmd_ext_mem_model
`default_nettype wire

/* File: verification/mmd_decode_bench.sv */
// Self-checking testbench for the memory map decoder
`default_nettype none
module mmd_decode_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk_in = 1'b0, rst_in = 1'b1, ce_in = 1'b1, host_io_in = 1'b0;
  logic data_page_we_in = 1'b0, jump_page_we_in = 1'b0;
  logic io_page_we_in = 1'b0, pc_step_in = 1'b0;
  logic [1:0]  ag_sel_in = '0;
  logic [2:0]  spcfg_we_in = '0, bank_first_we_in = '0;
  logic [7:0]  data_page_in = '0, jump_page_in = '0, io_page_in = '0;
  logic [7:0]  bank_first_in = '0;
  logic [9:0]  io_imm_in = '0;
  logic [15:0] ag_ptr_in = '0, pc_rel_in = '0, spcfg_in = '0;
  logic [23:0] pc_direct_in = '0;
  mmd_pkg::mmd_pcsel_t  pc_sel_in = mmd_pkg::MMD_PC_LINEAR;
  mmd_pkg::mmd_req_t    core_req_in = '0, dma_req_in = '0;
  logic [23:0] program_addr_bus_out, data_addr_out, ext_addr_out, pm_addr;
  logic [17:0] io_addr_out;
  mmd_pkg::mmd_intsel_t int_sel_out;
  logic [3:0]  bank_select_n_out;
  logic [2:0]  ext_clkdiv_out, pm_space;
  logic io_space_select_n_out, boot_space_select_n_out, ext_we_out;
  logic ext_bus8_out, ext_whold_out, core_stall_out, dma_stall_out;
  logic core_done_out, dma_done_out, pm_overlap, bus8_exp = 1'b0;
  logic [3:0]  wc_exp = 4'h0;
  logic [31:0] rnd = 32'h51b2_b2ea;
  logic [7:0]  b1 = 8'h40, b2 = 8'h80, b3 = 8'hC0, pg;
  logic [23:0] pc;
  logic [63:0] pages = 64'h013F_407F_80BF_C0FE;
  int fails = 0, cmp_count = 0, n;
  mmd_pkg::mmd_req_t rq;

  // Clock at 250 MHz
  always #2 mclk_in = ~mclk_in;

  mmd_decode i_dut (
    .mclk_in(mclk_in), .rst_in(rst_in), .ce_in(ce_in),
    .ag_sel_in(ag_sel_in), .ag_ptr_in(ag_ptr_in),
    .data_page_we_in(data_page_we_in), .data_page_in(data_page_in),
    .pc_sel_in(pc_sel_in), .pc_step_in(pc_step_in), .pc_rel_in(pc_rel_in),
    .pc_direct_in(pc_direct_in), .jump_page_we_in(jump_page_we_in),
    .jump_page_in(jump_page_in), .io_page_we_in(io_page_we_in),
    .io_page_in(io_page_in), .io_imm_in(io_imm_in),
    .spcfg_we_in(spcfg_we_in), .spcfg_in(spcfg_in),
    .bank_first_we_in(bank_first_we_in), .bank_first_in(bank_first_in),
    .core_req_in(core_req_in), .dma_req_in(dma_req_in),
    .host_io_in(host_io_in),
    .program_addr_bus_out(program_addr_bus_out),
    .data_addr_out(data_addr_out), .io_addr_out(io_addr_out),
    .int_sel_out(int_sel_out), .bank_select_n_out(bank_select_n_out),
    .io_space_select_n_out(io_space_select_n_out),
    .boot_space_select_n_out(boot_space_select_n_out),
    .ext_addr_out(ext_addr_out), .ext_we_out(ext_we_out),
    .ext_bus8_out(ext_bus8_out), .ext_whold_out(ext_whold_out),
    .ext_clkdiv_out(ext_clkdiv_out), .core_stall_out(core_stall_out),
    .dma_stall_out(dma_stall_out), .core_done_out(core_done_out),
    .dma_done_out(dma_done_out));
  mmd_ext_mem_model i_mem (.mclk_in(mclk_in),
    .bank_select_n_in(bank_select_n_out),
    .io_space_select_n_in(io_space_select_n_out),
    .boot_space_select_n_in(boot_space_select_n_out),
    .ext_addr_in(ext_addr_out), .space_out(pm_space),
    .addr_out(pm_addr), .overlap_out(pm_overlap));

  // Random source
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : lfsr

  // Bank chosen by the current boundaries
  function automatic logic [2:0] bank_of(input logic [7:0] p);
    return (p < b1) ? 3'd0 : (p < b2) ? 3'd1 : (p < b3) ? 3'd2 : 3'd3;
  endfunction : bank_of

  // Comparison with report
  task automatic chk(input string nm, input logic [23:0] e, g);
    cmp_count++;
    if (g !== e) begin
      fails++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // Verdict and end of run
  task automatic finish_test();
    $display("checks %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : finish_test

  // Bounded wait for a done pulse, counting edges
  task automatic wait_done(input logic dma, output int k);
    k = 0;
    do begin
      @(negedge mclk_in);
      k++;
    end while ((dma ? dma_done_out : core_done_out) !== 1'b1 && k < 64);
    if (k >= 64) begin
      fails++;
      $display("BAD done_wait expected 1 seen 0");
      finish_test();
    end
  endtask : wait_done

  // One core access to an off-chip space
  task automatic access(input mmd_pkg::mmd_req_t r, input int wt,
                        input logic [2:0] sp);
    int k;
    core_req_in = r;
    wait_done(1'b0, k);
    chk("latency", 24'(wt + 2), 24'(k));
    chk("space", {21'h0, sp}, {21'h0, pm_space});
    chk("ext_addr", r.addr, ext_addr_out);
    chk("ext_we", {23'h0, r.write}, {23'h0, ext_we_out});
    chk("bus8", {23'h0, bus8_exp}, {23'h0, ext_bus8_out});
    chk("whold_div", {20'h0, wc_exp},
        {20'h0, ext_whold_out, ext_clkdiv_out});
    core_req_in.req = 1'b0;
    @(negedge mclk_in);
  endtask : access

  initial begin
    repeat (4) @(negedge mclk_in);
    rst_in = 1'b0;
    chk("reset_pc", mmd_pkg::RESET_PC, program_addr_bus_out);
    chk("idle_sel", 24'h3F, {18'h0, boot_space_select_n_out,
        io_space_select_n_out, bank_select_n_out});
    // Data and I/O address forming, page corners then random
    for (int i = 0; i < 24; i++) begin
      rnd = lfsr(rnd);
      pg = (i < 4) ? pages[63 - 8 * i -: 8] : rnd[31:24];
      if (i < 2) pg = i[0] ? 8'hFF : 8'h00;
      ag_sel_in = {1'b0, rnd[20]};
      data_page_in = pg;
      io_page_in = (i < 2) ? 8'h07 + 8'(i) : rnd[7:0];
      data_page_we_in = 1'b1;
      io_page_we_in = 1'b1;
      host_io_in = rnd[9];
      @(negedge mclk_in);
      data_page_we_in = 1'b0;
      io_page_we_in = 1'b0;
      ag_ptr_in = (i == 1) ? 16'hFC00 : (i == 2) ? 16'hFBFF : rnd[15:0];
      io_imm_in = rnd[25:16];
      #1;
      chk("data_addr", {pg, ag_ptr_in}, data_addr_out);
      chk("io_addr", {6'h0, io_page_in, io_imm_in}, 24'(io_addr_out));
      chk("int_sel", {19'h0, pg == 8'h00, pg == 8'h00 ? ag_ptr_in[15:14]
          : 2'b0, pg == 8'hFF && ag_ptr_in >= 16'hFC00,
          (io_page_in <= 8'h07) && host_io_in}, {19'h0, int_sel_out.sram,
          pg == 8'h00 ? int_sel_out.sram_blk : 2'b0, int_sel_out.rom,
          int_sel_out.io_int});
    end
    // Sequencer: direct, relative backwards, indirect, linear
    @(negedge mclk_in);
    pc_sel_in = mmd_pkg::MMD_PC_DIRECT;
    pc_direct_in = rnd[23:0];
    pc_step_in = 1'b1;
    @(negedge mclk_in);
    chk("pc_direct", pc_direct_in, program_addr_bus_out);
    pc = program_addr_bus_out;
    pc_sel_in = mmd_pkg::MMD_PC_REL;
    pc_rel_in = 16'h8000;
    jump_page_we_in = 1'b1;
    jump_page_in = rnd[31:24];
    @(negedge mclk_in);
    jump_page_we_in = 1'b0;
    chk("pc_rel", pc + {{8{1'b1}}, 16'h8000}, program_addr_bus_out);
    pc_sel_in = mmd_pkg::MMD_PC_IND;
    @(negedge mclk_in);
    chk("pc_ind", {jump_page_in, ag_ptr_in}, program_addr_bus_out);
    pc_sel_in = mmd_pkg::MMD_PC_LINEAR;
    @(negedge mclk_in);
    pc_step_in = 1'b0;
    chk("pc_lin", {jump_page_in, ag_ptr_in} + 24'h1,
        program_addr_bus_out);
    // Clock enable low freezes the fetch counter
    ce_in = 1'b0;
    pc_step_in = 1'b1;
    repeat (2) @(negedge mclk_in);
    chk("ce_hold", {jump_page_in, ag_ptr_in} + 24'h1,
        program_addr_bus_out);
    ce_in = 1'b1;
    pc_step_in = 1'b0;
    // Reset bank boundaries, each edge page
    for (int i = 0; i < 8; i++) begin
      rnd = lfsr(rnd);
      rq = '{req: 1'b1, write: rnd[0], io: 1'b0, boot: 1'b0,
             addr: {pages[63 - 8 * i -: 8], rnd[23:8]}};
      access(rq, 7, bank_of(rq.addr[23:16]));
    end
    // External I/O page and boot page
    rq = '{1'b1, 1'b0, 1'b1, 1'b0, {6'h0, 8'h08 + 8'(rnd[6:0]), rnd[9:0]}};
    access(rq, 7, 3'd4);
    rq = '{1'b1, 1'b1, 1'b0, 1'b1, {8'h3E, rnd[15:0]}};
    access(rq, 7, 3'd5);
    // New bank 0 timing, 8-bit path, moved boundary
    spcfg_we_in = 3'b001;
    spcfg_in = {3'b001, 1'b0, rnd[30], rnd[23:21], 2'b00, rnd[26:24],
                rnd[29:27]};
    bank_first_we_in = 3'b001;
    bank_first_in = 8'h20;
    @(negedge mclk_in);
    spcfg_we_in = '0;
    bank_first_we_in = '0;
    b1 = 8'h20;
    bus8_exp = 1'b1;
    wc_exp = spcfg_in[11:8];
    rq = '{1'b1, 1'b1, 1'b0, 1'b0, 24'h10_5555};
    access(rq, int'(spcfg_in[5:3]), 3'd0);
    rq = '{1'b1, 1'b0, 1'b0, 1'b0, 24'h1F_AAAA};
    access(rq, int'(spcfg_in[2:0]), 3'd0);
    bus8_exp = 1'b0;
    wc_exp = 4'h0;
    // Internal I/O page is never sequenced
    core_req_in = '{1'b1, 1'b0, 1'b1, 1'b0, 24'h00_0C00};
    @(negedge mclk_in);
    chk("int_io", 24'h1, {22'h0, core_stall_out, io_space_select_n_out});
    core_req_in.req = 1'b0;
    // Tie: core served first, DMA stalled, then served
    @(negedge mclk_in);
    core_req_in = '{1'b1, 1'b0, 1'b0, 1'b0, 24'h85_0001};
    dma_req_in = '{1'b1, 1'b1, 1'b0, 1'b0, 24'hC7_0002};
    @(negedge mclk_in);
    chk("dma_stall", 24'h1, {23'h0, dma_stall_out});
    wait_done(1'b0, n);
    chk("core_space", 24'h2, {21'h0, pm_space});
    core_req_in.req = 1'b0;
    wait_done(1'b1, n);
    chk("dma_space", 24'h3, {21'h0, pm_space});
    dma_req_in.req = 1'b0;
    chk("overlap", 24'h0, {23'h0, pm_overlap});
    finish_test();
  end
endmodule : mmd_decode_bench
`default_nettype wire
